// >>> smfr_pkg.sv
package smfr_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 25;
    localparam int FILT_TIME_NS = 10000;
    localparam int FILT_CYC = (FILT_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int ST_TIME_US = 300;
    localparam int ST_CYC = (ST_TIME_US * 1000) / CLK_NS;
    localparam int ST_TOGGLES = 4;
    localparam logic [3:0] TALLY_LIMIT = 4'h5;
    localparam logic [7:0] STAT_RST = 8'h00;
    // ----------------------------------------
    // Comparator indices
    // ----------------------------------------
    localparam int C_BAT_UV = 0;
    localparam int C_BAT_OV = 1;
    localparam int C_PRE_UV = 2;
    localparam int C_PRE_OV = 3;
    localparam int C_CAN_UV = 4;
    localparam int C_CAN_OV = 5;
    localparam int C_IO_UV = 6;
    localparam int C_IO_OV = 7;
    localparam int C_CORE_UV = 8;
    localparam int C_CORE_OV = 9;
    localparam int C_SENS_UV = 10;
    localparam int C_SENS_OV = 11;
    localparam int C_PH_OV = 12;
    localparam int C_PL_UV = 13;
    localparam int C_PL_OV = 14;
    localparam int C_ANA_UV = 15;
    localparam int C_ANA_OV = 16;
    localparam int C_MON_UV = 17;
    localparam int C_MON_OV = 18;
    localparam int C_LOG_UV = 19;
    localparam int C_LOG_OV = 20;
    localparam int C_RREF_UV = 21;
    localparam int C_RREF_OV = 22;
    localparam int C_MREF_UV = 23;
    localparam int C_MREF_OV = 24;
    localparam int NCMP = 25;
    // ----------------------------------------
    // Status bit positions
    // ----------------------------------------
    localparam int S1_BAT_OV = 7;
    localparam int S1_BAT_UV = 6;
    localparam int S1_PH_OV = 5;
    localparam int S1_PL_OV = 4;
    localparam int S1_PL_UV = 3;
    localparam int S1_MON_UV = 2;
    localparam int S1_REF_B1 = 1;
    localparam int S1_REF_B0 = 0;
    localparam int S2_PRE_OV = 7;
    localparam int S2_PRE_UV = 6;
    localparam int S2_CAN_OV = 5;
    localparam int S2_CAN_UV = 4;
    localparam int S2_IO_OV = 3;
    localparam int S2_IO_UV = 2;
    localparam int S2_CORE_OV = 1;
    localparam int S2_CORE_UV = 0;
    localparam int SF_SENS_UV = 5;
    localparam int SF_SENS_OV = 4;
    // ----------------------------------------
    // State encodings
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_SELFTEST = 3'h1,
        ST_RESET = 3'h2,
        ST_DIAG = 3'h3,
        ST_ACTIVE = 3'h4,
        ST_SAFE = 3'h5
    } smfr_state_t;
    typedef enum logic [1:0] {
        B_IDLE = 2'h0,
        B_FORCE = 2'h1,
        B_RELEASE = 2'h2,
        B_DONE = 2'h3
    } smfr_bist_t;
endpackage

// >>> smfr_glitch_filter.sv
`timescale 1ns/1ps
module smfr_glitch_filter #(
    parameter int N = 1,
    parameter int CYC = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [N-1:0] raw,
    output logic [N-1:0] sync_q,
    output logic [N-1:0] filt_q
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(CYC - 1);

    logic [N-1:0] meta_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    // ----------------------------------------
    // Per-bit stability counters
    // ----------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_bit
        logic [CW-1:0] cnt_q;
        logic bit_q;
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                cnt_q <= '0;
                bit_q <= 1'b0;
            end else if (sync_q[i] == bit_q) begin
                cnt_q <= '0;
            end else if (cnt_q == CNT_LAST) begin
                cnt_q <= '0;
                bit_q <= sync_q[i];
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
        // One process per bit, so each bit gets its own flop
        assign filt_q[i] = bit_q;
    end

    glitch_reject_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(filt_q[0]) |-> $past(sync_q[0], 1) && $past(sync_q[0], 2))
        else $error("filtered flag set by a short pulse");
endmodule // smfr_glitch_filter

// >>> smfr_self_test.sv
`timescale 1ns/1ps
module smfr_self_test #(
    parameter int N = 1,
    parameter int RUN_CYC = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [N-1:0] cmp_sync,
    output logic emulate_q,
    output logic running,
    output logic fail_q
);
    localparam int PH = RUN_CYC / (2 * smfr_pkg::ST_TOGGLES);
    localparam int PW = $clog2(PH + 1);
    localparam logic [PW-1:0] PH_LAST = PW'(PH - 1);
    localparam logic [2:0] TG_LAST = 3'(smfr_pkg::ST_TOGGLES - 1);

    smfr_pkg::smfr_bist_t st_q;
    logic [PW-1:0] ph_q;
    logic [2:0] tg_q;
    logic err_q;
    logic ph_end;

    assign ph_end = (ph_q == PH_LAST);
    assign running = (st_q != smfr_pkg::B_IDLE);

    // ----------------------------------------
    // Toggle sequence
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= smfr_pkg::B_IDLE;
            ph_q <= '0;
            tg_q <= '0;
        end else begin
            ph_q <= (st_q == smfr_pkg::B_IDLE || ph_end) ? '0 : ph_q + 1'b1;
            unique case (st_q)
                smfr_pkg::B_IDLE: begin
                    tg_q <= '0;
                    if (start) begin
                        st_q <= smfr_pkg::B_FORCE;
                    end
                end
                smfr_pkg::B_FORCE: begin
                    if (ph_end) begin
                        st_q <= smfr_pkg::B_RELEASE;
                    end
                end
                smfr_pkg::B_RELEASE: begin
                    if (ph_end && tg_q == TG_LAST) begin
                        st_q <= smfr_pkg::B_DONE;
                    end else if (ph_end) begin
                        tg_q <= tg_q + 1'b1;
                        st_q <= smfr_pkg::B_FORCE;
                    end
                end
                smfr_pkg::B_DONE: begin
                    st_q <= smfr_pkg::B_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            emulate_q <= 1'b0;
        end else begin
            emulate_q <= (st_q == smfr_pkg::B_FORCE) && !ph_end
                || (st_q == smfr_pkg::B_RELEASE) && ph_end && tg_q != TG_LAST;
        end
    end

    // ----------------------------------------
    // Pattern check at each phase end
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            err_q <= 1'b0;
            fail_q <= 1'b0;
        end else if (st_q == smfr_pkg::B_IDLE && start) begin
            err_q <= 1'b0;
            fail_q <= 1'b0;
        end else if (st_q == smfr_pkg::B_FORCE && ph_end && !(&cmp_sync)) begin
            err_q <= 1'b1;
        end else if (st_q == smfr_pkg::B_RELEASE && ph_end && (|cmp_sync)) begin
            err_q <= 1'b1;
        end else if (st_q == smfr_pkg::B_DONE) begin
            fail_q <= err_q;
        end
    end

    emulate_phase_a: assert property (@(posedge clk) disable iff (!rstn)
        st_q == smfr_pkg::B_FORCE && $past(st_q) == smfr_pkg::B_FORCE |-> emulate_q)
        else $error("comparators not forced during force phase");
endmodule // smfr_self_test

// >>> smfr_supply_monitor.sv
`timescale 1ns/1ps
module smfr_supply_monitor #(
    parameter int ST_RUN_CYC = smfr_pkg::ST_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [smfr_pkg::NCMP-1:0] cmp_raw,
    input wire logic logic_self_test_done,
    input wire logic logic_self_test_fail,
    input wire logic self_test_request,
    input wire logic go_active,
    input wire logic battery_overvoltage_ignore,
    input wire logic core_rail_fault_act,
    input wire logic output_drive_permit,
    input wire logic [3:0] watchdog_failure_tally,
    output logic [7:0] monitor_status_one,
    output logic [7:0] monitor_status_two,
    output logic [7:0] safety_status_one,
    output logic [2:0] device_state,
    output logic mcu_reset_n,
    output logic power_stage_enable,
    output logic internal_poweron_reset,
    output logic comparator_emulate,
    output logic self_test_running,
    output logic self_test_failed,
    output logic spi_ready,
    output logic sensor_rail_off,
    output logic pump_rails_off
);
    logic [smfr_pkg::NCMP-1:0] cmp_sync;
    logic [smfr_pkg::NCMP-1:0] cmp_filt;
    logic [smfr_pkg::NCMP-1:0] vec_q;
    smfr_pkg::smfr_state_t state_q;
    smfr_pkg::smfr_state_t state_d;
    logic st_start;
    logic st_running;
    logic st_fail;
    logic por_f;
    logic stby_f;
    logic rst_f;
    logic drv_f;
    logic run_state;
    logic mcu_reset_n_q;
    logic pse_q;
    logic por_q;
    logic sens_off_q;
    logic pump_off_q;
    logic [7:0] stat1_q;
    logic [7:0] stat2_q;
    logic [7:0] safe1_q;

    // ----------------------------------------
    // Filtering and self-test
    // ----------------------------------------
    smfr_glitch_filter #(
        .N(smfr_pkg::NCMP),
        .CYC(smfr_pkg::FILT_CYC)
    ) u_filter (
        .clk(clk),
        .rstn(rstn),
        .raw(cmp_raw),
        .sync_q(cmp_sync),
        .filt_q(cmp_filt)
    );

    smfr_self_test #(
        .N(smfr_pkg::NCMP),
        .RUN_CYC(ST_RUN_CYC)
    ) u_self_test (
        .clk(clk),
        .rstn(rstn),
        .start(st_start),
        .cmp_sync(cmp_sync),
        .emulate_q(comparator_emulate),
        .running(st_running),
        .fail_q(st_fail)
    );

    assign run_state = (state_q == smfr_pkg::ST_DIAG) || (state_q == smfr_pkg::ST_ACTIVE);

    // Request outside DIAGNOSTIC or ACTIVE is dropped
    assign st_start = !st_running && !stby_f
        && ((state_q == smfr_pkg::ST_STANDBY && !vec_q[smfr_pkg::C_PRE_UV])
        || (run_state && self_test_request));

    // Rails are not watched during a run, so the last picture is held
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vec_q <= '0;
        end else if (!st_running) begin
            vec_q <= cmp_filt;
        end
    end

    // ----------------------------------------
    // Fault classes
    // ----------------------------------------
    assign por_f = vec_q[smfr_pkg::C_ANA_UV] || vec_q[smfr_pkg::C_ANA_OV]
        || vec_q[smfr_pkg::C_LOG_UV] || vec_q[smfr_pkg::C_LOG_OV]
        || vec_q[smfr_pkg::C_MON_OV];
    assign stby_f = por_f || vec_q[smfr_pkg::C_BAT_UV];
    assign rst_f = (vec_q[smfr_pkg::C_BAT_OV] && !battery_overvoltage_ignore)
        || vec_q[smfr_pkg::C_IO_UV]
        || (vec_q[smfr_pkg::C_CORE_UV] && core_rail_fault_act)
        || vec_q[smfr_pkg::C_PL_OV];
    assign drv_f = vec_q[smfr_pkg::C_CAN_OV]
        || vec_q[smfr_pkg::C_IO_OV]
        || (vec_q[smfr_pkg::C_CORE_OV] && core_rail_fault_act);

    // ----------------------------------------
    // Device state controller
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            smfr_pkg::ST_STANDBY: begin
                if (st_start) begin
                    state_d = smfr_pkg::ST_SELFTEST;
                end
            end
            smfr_pkg::ST_SELFTEST: begin
                if (!st_running && logic_self_test_done) begin
                    state_d = (st_fail || logic_self_test_fail) ? smfr_pkg::ST_SAFE
                        : smfr_pkg::ST_RESET;
                end
            end
            smfr_pkg::ST_RESET: begin
                if (!rst_f) begin
                    state_d = smfr_pkg::ST_DIAG;
                end
            end
            smfr_pkg::ST_DIAG: begin
                if (go_active) begin
                    state_d = smfr_pkg::ST_ACTIVE;
                end
            end
            smfr_pkg::ST_ACTIVE: begin
                state_d = smfr_pkg::ST_ACTIVE;
            end
            smfr_pkg::ST_SAFE: begin
                state_d = smfr_pkg::ST_SAFE;
            end
            default: begin
                state_d = smfr_pkg::ST_STANDBY;
            end
        endcase
        if (run_state && !st_running && st_fail) begin
            state_d = smfr_pkg::ST_SAFE;
        end
        if (run_state && rst_f) begin
            state_d = smfr_pkg::ST_RESET;
        end
        if (stby_f) begin
            state_d = smfr_pkg::ST_STANDBY;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= smfr_pkg::ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mcu_reset_n_q <= 1'b0;
            pse_q <= 1'b0;
            por_q <= 1'b0;
            sens_off_q <= 1'b0;
            pump_off_q <= 1'b0;
        end else begin
            mcu_reset_n_q <= (state_q != smfr_pkg::ST_STANDBY)
                && (state_q != smfr_pkg::ST_SELFTEST)
                && (state_q != smfr_pkg::ST_RESET);
            pse_q <= run_state && output_drive_permit
                && (watchdog_failure_tally < smfr_pkg::TALLY_LIMIT)
                && !drv_f && !rst_f && !stby_f
                && !st_running;
            por_q <= por_f;
            sens_off_q <= vec_q[smfr_pkg::C_PH_OV];
            pump_off_q <= vec_q[smfr_pkg::C_PL_OV];
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat1_q <= smfr_pkg::STAT_RST;
            stat2_q <= smfr_pkg::STAT_RST;
            safe1_q <= smfr_pkg::STAT_RST;
        end else begin
            stat1_q <= smfr_pkg::STAT_RST;
            stat2_q <= smfr_pkg::STAT_RST;
            safe1_q <= smfr_pkg::STAT_RST;
            stat1_q[smfr_pkg::S1_BAT_OV] <= vec_q[smfr_pkg::C_BAT_OV];
            stat1_q[smfr_pkg::S1_BAT_UV] <= vec_q[smfr_pkg::C_BAT_UV];
            stat1_q[smfr_pkg::S1_PH_OV] <= vec_q[smfr_pkg::C_PH_OV];
            stat1_q[smfr_pkg::S1_PL_OV] <= vec_q[smfr_pkg::C_PL_OV];
            stat1_q[smfr_pkg::S1_PL_UV] <= vec_q[smfr_pkg::C_PL_UV];
            stat1_q[smfr_pkg::S1_MON_UV] <= vec_q[smfr_pkg::C_MON_UV];
            stat1_q[smfr_pkg::S1_REF_B1] <= vec_q[smfr_pkg::C_RREF_OV]
                || vec_q[smfr_pkg::C_MREF_UV];
            stat1_q[smfr_pkg::S1_REF_B0] <= vec_q[smfr_pkg::C_RREF_UV]
                || vec_q[smfr_pkg::C_MREF_OV];
            stat2_q[smfr_pkg::S2_PRE_OV] <= vec_q[smfr_pkg::C_PRE_OV];
            stat2_q[smfr_pkg::S2_PRE_UV] <= vec_q[smfr_pkg::C_PRE_UV];
            stat2_q[smfr_pkg::S2_CAN_OV] <= vec_q[smfr_pkg::C_CAN_OV];
            stat2_q[smfr_pkg::S2_CAN_UV] <= vec_q[smfr_pkg::C_CAN_UV];
            stat2_q[smfr_pkg::S2_IO_OV] <= vec_q[smfr_pkg::C_IO_OV];
            stat2_q[smfr_pkg::S2_IO_UV] <= vec_q[smfr_pkg::C_IO_UV];
            stat2_q[smfr_pkg::S2_CORE_OV] <= vec_q[smfr_pkg::C_CORE_OV];
            stat2_q[smfr_pkg::S2_CORE_UV] <= vec_q[smfr_pkg::C_CORE_UV];
            safe1_q[smfr_pkg::SF_SENS_UV] <= vec_q[smfr_pkg::C_SENS_UV];
            safe1_q[smfr_pkg::SF_SENS_OV] <= vec_q[smfr_pkg::C_SENS_OV];
        end
    end

    // Flags are levels: a rail back in band reads 0 again
    assign monitor_status_one = stat1_q;
    assign monitor_status_two = stat2_q;
    assign safety_status_one = safe1_q;
    assign device_state = state_q;
    assign mcu_reset_n = mcu_reset_n_q;
    assign power_stage_enable = pse_q;
    assign internal_poweron_reset = por_q;
    assign self_test_running = st_running;
    assign self_test_failed = st_fail;
    assign spi_ready = (state_q != smfr_pkg::ST_SELFTEST);
    assign sensor_rail_off = sens_off_q;
    assign pump_rails_off = pump_off_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    bat_uv_standby_a: assert property (vec_q[smfr_pkg::C_BAT_UV]
        |=> state_q == smfr_pkg::ST_STANDBY && !power_stage_enable ##1 !mcu_reset_n)
        else $error("battery undervoltage did not force standby");
    bat_ov_reset_a: assert property (vec_q[smfr_pkg::C_BAT_OV] && !battery_overvoltage_ignore
        && !stby_f && run_state |=> state_q == smfr_pkg::ST_RESET)
        else $error("battery overvoltage did not force reset");
    io_uv_reset_a: assert property (vec_q[smfr_pkg::C_IO_UV] && !stby_f && run_state
        |=> state_q == smfr_pkg::ST_RESET ##1 !mcu_reset_n)
        else $error("io undervoltage did not force reset");
    tally_gate_a: assert property (watchdog_failure_tally >= smfr_pkg::TALLY_LIMIT
        || !output_drive_permit |=> !power_stage_enable)
        else $error("enable high with tally or permit blocking");
    drive_fault_a: assert property (drv_f |=> !power_stage_enable)
        else $error("enable high during rail overvoltage");
    selftest_drive_a: assert property (st_running |=> !power_stage_enable)
        else $error("enable high during self-test");
    pre_flag_a: assert property (!st_running && !$past(st_running) && cmp_filt[smfr_pkg::C_PRE_UV]
        |-> ##2 monitor_status_two[smfr_pkg::S2_PRE_UV])
        else $error("preregulator flag not set");
    ref_cross_a: assert property (!st_running && cmp_filt[smfr_pkg::C_MREF_UV]
        |-> ##2 monitor_status_one[smfr_pkg::S1_REF_B1])
        else $error("monitor reference flag on wrong bit");
    safe_on_fail_a: assert property (state_q == smfr_pkg::ST_SELFTEST && !st_running
        && logic_self_test_done && logic_self_test_fail && !stby_f
        |=> state_q == smfr_pkg::ST_SAFE)
        else $error("logic self-test failure did not reach safe");
    request_gate_a: assert property ($rose(st_running)
        |-> $past(state_q) != smfr_pkg::ST_RESET && $past(state_q) != smfr_pkg::ST_SAFE)
        else $error("self-test started in a forbidden state");
    por_flag_a: assert property (vec_q[smfr_pkg::C_LOG_OV] |=> internal_poweron_reset)
        else $error("internal power-on reset missing");

    reach_active_c: cover property (state_q == smfr_pkg::ST_DIAG ##1
        state_q == smfr_pkg::ST_ACTIVE);
    runtime_test_c: cover property (state_q == smfr_pkg::ST_ACTIVE && $fell(st_running));
    reach_safe_c: cover property ($rose(state_q == smfr_pkg::ST_SAFE));
endmodule // smfr_supply_monitor

// >>> smfr_comparator_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Comparator bank facing the monitor
// ----------------------------------------
module smfr_comparator_model (
    input wire logic emulate,
    input wire logic stuck,
    input wire logic [smfr_pkg::NCMP-1:0] rail_fault,
    output logic [smfr_pkg::NCMP-1:0] cmp_raw
);
    // Emulation trips every comparator, rails untouched; stuck models a bank that ignores emulation and follows rail_fault
    assign cmp_raw = (emulate && !stuck) ? {smfr_pkg::NCMP{1'b1}} : rail_fault;
endmodule // smfr_comparator_model

// >>> supply_monitor_fault_response_bench.sv
`timescale 1ns/1ps
module supply_monitor_fault_response_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [smfr_pkg::NCMP-1:0] flt = '0;
    logic [smfr_pkg::NCMP-1:0] cmp_raw;
    logic ltd = 1'b1, lfail = 1'b0, req = 1'b0, go = 1'b0, ign = 1'b1, act = 1'b0, permit = 1'b0;
    logic stuck = 1'b0;
    logic [3:0] tally = 4'h0;
    logic [7:0] s1, s2, sf;
    logic [2:0] st;
    logic rn, pse, por, emu, run, stf, spi_ready;
    logic sro, pro;
    int bad_count = 0;
    int n_compared = 0;
    // Flag-only and drive-gating faults: index, register, bit, enable level
    int fi[17] = '{2, 3, 4, 5, 7, 9, 10, 11, 13, 21, 23, 17, 12, 1, 22, 24, 8};
    int fr[17] = '{1, 1, 1, 1, 1, 1, 2, 2, 0, 0, 0, 0, 0, 0, 0, 0, 1};
    int fb[17] = '{6, 7, 4, 5, 3, 1, 5, 4, 3, 0, 1, 2, 5, 7, 1, 0, 0};
    logic fe[17] = '{1, 1, 1, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    int ri[4] = '{6, 8, 14, 1};
    int si[3] = '{0, 20, 18};
    always #12.5 clk = ~clk;
    smfr_comparator_model cmp_u (.emulate(emu), .stuck(stuck), .rail_fault(flt),
        .cmp_raw(cmp_raw));
    smfr_supply_monitor #(.ST_RUN_CYC(64)) dut_u (.clk(clk), .rstn(rstn), .cmp_raw(cmp_raw),
        .logic_self_test_done(ltd), .logic_self_test_fail(lfail), .self_test_request(req),
        .go_active(go), .battery_overvoltage_ignore(ign), .core_rail_fault_act(act),
        .output_drive_permit(permit), .watchdog_failure_tally(tally),
        .monitor_status_one(s1), .monitor_status_two(s2), .safety_status_one(sf),
        .device_state(st), .mcu_reset_n(rn), .power_stage_enable(pse),
        .internal_poweron_reset(por), .comparator_emulate(emu), .self_test_running(run),
        .self_test_failed(stf), .spi_ready(spi_ready), .sensor_rail_off(sro),
        .pump_rails_off(pro));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Bounded wait; a state never reached shows up as a mismatch
    task automatic wait_st(input logic [2:0] exp);
        for (int k = 0; k < 2000 && st !== exp; k++) tick(1);
        check("state", {5'h00, st}, {5'h00, exp});
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        #2 rstn = 1'b1;
        wait_st(3'h1);
        tick(2);
        check("running", {7'h00, run}, 8'h01);
        check("pse_run", {7'h00, pse}, 8'h00);
        check("spi_run", {7'h00, spi_ready}, 8'h00);
        wait_st(3'h3);
        check("failed", {7'h00, stf}, 8'h00);
        check("spi", {7'h00, spi_ready}, 8'h01);
        permit = 1'b1;
        tally = 4'h4;
        tick(2);
        check("pse_4", {6'h00, rn, pse}, 8'h03);
        tally = 4'h5;
        tick(2);
        check("pse_5", {7'h00, pse}, 8'h00);
        tally = 4'h4;
        $display("test power-up done");
        for (int k = 0; k < 17; k++) begin
            flt[fi[k]] = 1'b1;
            tick(410);
            check("flag", fr[k] == 0 ? s1 : fr[k] == 1 ? s2 : sf, 8'h01 << fb[k]);
            check("pse_flag", {7'h00, pse}, {7'h00, fe[k]});
            check("st_flag", {5'h00, st}, 8'h03);
            check("sens_off", {7'h00, sro}, {7'h00, fi[k] == smfr_pkg::C_PH_OV});
            flt = '0;
            tick(410);
            check("clear", s1 | s2 | sf, 8'h00);
        end
        flt[smfr_pkg::C_CAN_OV] = 1'b1;
        tick(100);
        flt = '0;
        tick(420);
        check("glitch", s2, 8'h00);
        $display("test flags done");
        ign = 1'b0;
        act = 1'b1;
        for (int k = 0; k < 4; k++) begin
            flt[ri[k]] = 1'b1;
            wait_st(3'h2);
            tick(2);
            check("rst_n", {6'h00, rn, pse}, 8'h00);
            check("pump_off", {7'h00, pro}, {7'h00, ri[k] == smfr_pkg::C_PL_OV});
            flt = '0;
            wait_st(3'h3);
        end
        flt[smfr_pkg::C_CORE_OV] = 1'b1;
        tick(410);
        check("core_ov", {4'h0, st, pse}, 8'h06);
        flt = '0;
        tick(410);
        check("core_clr", {7'h00, pse}, 8'h01);
        $display("test reset faults done");
        for (int k = 0; k < 3; k++) begin
            flt[si[k]] = 1'b1;
            flt[smfr_pkg::C_IO_UV] = 1'b1;
            wait_st(3'h0);
            tick(2);
            check("stby", {5'h00, rn, pse, por}, {7'h00, k != 0});
            flt = '0;
            wait_st(3'h3);
        end
        $display("test standby faults done");
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_st(3'h4);
        for (int k = 0; k < 2; k++) begin
            stuck = k[0];
            req = 1'b1;
            tick(1);
            req = 1'b0;
            tick(2);
            check("req_run", {6'h00, run, pse}, 8'h02);
            check("emulate", {7'h00, emu}, 8'h01);
            tick(80);
            check("result", {6'h00, run, stf}, {7'h00, k[0]});
        end
        wait_st(3'h5);
        req = 1'b1;
        tick(3);
        check("refused", {7'h00, run}, 8'h00);
        $display("test self-test request done");
        req = 1'b0;
        stuck = 1'b0;
        lfail = 1'b1;
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        wait_st(3'h1);
        wait_st(3'h5);
        check("logic_self_test", {7'h00, stf}, 8'h00);
        $display("test logic self-test failure done");
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule // supply_monitor_fault_response_bench
